// ==== design/arb_bank.sv ====
// register bank, serial port and power-on sequencer of the converter
// assumes serial pins are already synchronous to clock and sclk is slow
//
// What this block does
// - reset loads defaults, settles modulator, self-calibrates at 850 Hz data rate
// - after power-on calibration the sequencer core enters convert state
// - conversion_result holds the latest completed 24-bit conversion
// - raw values corrected by offset_trim and gain_trim before storing
// - offset trim comes from calibration or host writes, gain trim from host writes only, used identically
// - instruction_byte cannot be read back
// - control_word is 32 bits: gain, oversampling factor, decimation, mode
// - control_word, result and both trims are host readable and writable
// - reference generator enabled after reset, control word may disable
// - bias generator disabled after reset until host enables it
// - sampling rate scales with gain and oversampling factor
// - instruction holds read flag, byte count and start byte address
// - control_word byte takes effect on falling clock of its last bit
module arb_bank #(
    parameter int SETTLE_CYC = 256
) (
    // ************************************************************
    // clock and reset
    // ************************************************************
    input wire logic clock,
    input wire logic rstn,
    // ************************************************************
    // serial port
    // ************************************************************
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    // ************************************************************
    // modulator and filter
    // ************************************************************
    input wire logic [23:0] raw_data,
    input wire logic raw_valid,
    output logic cal_short,
    output logic [12:0] decimation,
    output logic [2:0] pga_gain,
    output logic [2:0] oversampling_rate_factor,
    output logic [2:0] op_mode,
    output logic [7:0] samp_mult,
    // ************************************************************
    // analog enables and status
    // ************************************************************
    output logic ref_enable,
    output logic bias_enable,
    output logic in_convert,
    output logic data_ready
);

    // ************************************************************
    // sequencer core
    // ************************************************************
    arb_pkg::arb_seq_e seq_r;
    arb_pkg::arb_seq_e seq_nxt;
    logic [15:0] settle_r;
    logic [1:0] calcnt_r;
    logic corr_valid;
    logic [23:0] corr;
    logic cal_take;
    logic [31:0] ctl_r;
    logic [23:0] res_r;
    logic [23:0] ofs_r;
    logic [23:0] gan_r;
    logic [23:0] res_fmt;
    logic rdy_r;

    assign cal_take = (seq_r == arb_pkg::SEQ_CAL) && raw_valid && (calcnt_r == arb_pkg::CAL_FILL);

    always_comb begin
        seq_nxt = seq_r;
        unique case (seq_r)
            arb_pkg::SEQ_RESET: begin
                if (settle_r == 16'(SETTLE_CYC - 1)) begin
                    seq_nxt = arb_pkg::SEQ_CAL;
                end
            end
            arb_pkg::SEQ_CAL: begin
                if (cal_take) begin
                    seq_nxt = arb_pkg::SEQ_CONV;
                end
            end
            arb_pkg::SEQ_CONV: seq_nxt = arb_pkg::SEQ_CONV;
            default: seq_nxt = arb_pkg::SEQ_RESET;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seq_r <= arb_pkg::SEQ_RESET;
            settle_r <= 16'h0000;
            calcnt_r <= 2'h0;
        end else begin
            seq_r <= seq_nxt;
            settle_r <= (seq_r == arb_pkg::SEQ_RESET) ? settle_r + 16'h0001 : 16'h0000;
            calcnt_r <= (seq_r == arb_pkg::SEQ_CAL && raw_valid) ? calcnt_r + 2'h1 : calcnt_r;
        end
    end

    // ************************************************************
    // serial port
    // ************************************************************
    logic sclk_q_r;
    logic rise;
    logic fall;
    logic [2:0] bit_r;
    logic [7:0] shift_r;
    logic in_data_r;
    arb_pkg::arb_ins_s ins_r;
    logic [3:0] addr_r;
    logic [1:0] left_r;
    logic done_r;
    logic [7:0] rd_byte;
    logic [7:0] out_r;
    logic [23:0] snap_r;
    logic byte_end;
    logic [7:0] wr_byte;
    logic wr_go;
    logic [3:0] addr_step;
    logic load_r;

    assign rise = sclk && !sclk_q_r;
    assign fall = !sclk && sclk_q_r;
    assign byte_end = fall && (bit_r == 3'h7) && !done_r;
    assign wr_byte = shift_r;
    assign wr_go = byte_end && in_data_r && !ins_r.rd;
    // decrement only applies to reads
    assign addr_step = (ins_r.rd && ctl_r[arb_pkg::CW_BD]) ? addr_r - 4'h1 : addr_r + 4'h1;

    // the instruction has no address, so it can never be read back
    assign rd_byte = (addr_r <= arb_pkg::A_RES_B0) ? snap_r[8 * (2 - addr_r[1:0]) +: 8] :
                     (addr_r >= arb_pkg::A_CTL_B3 && addr_r <= arb_pkg::A_CTL_B0) ?
                         ctl_r[8 * (3 - addr_r[1:0]) +: 8] :
                     (addr_r >= arb_pkg::A_OFS_B2 && addr_r <= arb_pkg::A_OFS_B0) ?
                         ofs_r[8 * (2 - addr_r[1:0]) +: 8] :
                     (addr_r >= arb_pkg::A_GAN_B2 && addr_r <= arb_pkg::A_GAN_B0) ?
                         gan_r[8 * (2 - addr_r[1:0]) +: 8] : 8'h00;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_q_r <= 1'b0;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            in_data_r <= 1'b0;
            ins_r <= '0;
            addr_r <= 4'h0;
            left_r <= 2'h0;
            done_r <= 1'b0;
            out_r <= 8'h00;
            snap_r <= 24'h00_0000;
            load_r <= 1'b0;
        end else if (cs_n) begin
            sclk_q_r <= sclk;
            bit_r <= 3'h0;
            in_data_r <= 1'b0;
            done_r <= 1'b0;
            load_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk;
            if (rise) begin
                shift_r <= {shift_r[6:0], sdio_in};
            end
            if (fall) begin
                bit_r <= bit_r + 3'h1;
                out_r <= {out_r[6:0], 1'b0};
            end
            if (byte_end && !in_data_r) begin
                // first byte of every transaction is the instruction
                ins_r <= shift_r;
                addr_r <= shift_r[3:0];
                left_r <= shift_r[6:5];
                in_data_r <= 1'b1;
                // freeze the result so a multi-byte read sees one conversion
                snap_r <= res_r;
            end else if (byte_end) begin
                addr_r <= addr_step;
                left_r <= left_r - 2'h1;
                done_r <= (left_r == 2'h0);
            end
            // load one clock after a byte ends, once addr_r has stepped
            load_r <= byte_end && (in_data_r ? (ins_r.rd && left_r != 2'h0) : shift_r[7]);
            if (load_r) begin
                out_r <= rd_byte;
            end
        end
    end

    // the host samples each bit well after the load, so the extra clock costs nothing
    assign sdio_oe = !cs_n && in_data_r && ins_r.rd && !done_r;
    assign sdio_out = out_r[7];

    // ************************************************************
    // registers
    // ************************************************************
    arb_correct u_corr (
        .clock(clock),
        .rstn(rstn),
        .raw(raw_data),
        .raw_valid(raw_valid && seq_r == arb_pkg::SEQ_CONV),
        .ofs(ofs_r),
        .gain(gan_r),
        .corr(corr),
        .corr_valid(corr_valid)
    );

    // unipolar clamp, then offset binary flips the sign bit
    assign res_fmt = {(ctl_r[arb_pkg::CW_UB] && corr[23] ? 1'b0 : corr[23]) ^ ctl_r[arb_pkg::CW_DF],
                      (ctl_r[arb_pkg::CW_UB] && corr[23]) ? 23'h00_0000 : corr[22:0]};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= arb_pkg::CW_RESET;
            res_r <= 24'h00_0000;
            ofs_r <= arb_pkg::OFS_RESET;
            gan_r <= arb_pkg::GAN_RESET;
            rdy_r <= 1'b0;
        end else begin
            if (wr_go && addr_r >= arb_pkg::A_CTL_B3 && addr_r <= arb_pkg::A_CTL_B0) begin
                ctl_r[8 * (3 - addr_r[1:0]) +: 8] <= wr_byte;
            end
            // a fresh conversion wins over a host write in the same cycle
            if (corr_valid) begin
                res_r <= res_fmt;
            end else if (wr_go && addr_r <= arb_pkg::A_RES_B0) begin
                res_r[8 * (2 - addr_r[1:0]) +: 8] <= wr_byte;
            end
            if (cal_take) begin
                ofs_r <= raw_data;
            end else if (wr_go && addr_r >= arb_pkg::A_OFS_B2 && addr_r <= arb_pkg::A_OFS_B0) begin
                ofs_r[8 * (2 - addr_r[1:0]) +: 8] <= wr_byte;
            end
            if (wr_go && addr_r >= arb_pkg::A_GAN_B2 && addr_r <= arb_pkg::A_GAN_B0) begin
                gan_r[8 * (2 - addr_r[1:0]) +: 8] <= wr_byte;
            end
            rdy_r <= corr_valid ? 1'b1 : (byte_end && in_data_r && ins_r.rd && addr_r == arb_pkg::A_RES_B0)
                     ? 1'b0 : rdy_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cal_short = (seq_r == arb_pkg::SEQ_CAL);
    assign decimation = (seq_r == arb_pkg::SEQ_CONV) ? ctl_r[arb_pkg::CW_DR_LO +: 13] : arb_pkg::CAL_DECIM;
    assign pga_gain = ctl_r[arb_pkg::CW_G_LO +: 3];
    assign oversampling_rate_factor = ctl_r[arb_pkg::CW_SF_LO +: 3];
    assign op_mode = ctl_r[arb_pkg::CW_MD_LO +: 3];
    // rate multiple is 2^gain * 2^factor; capped so the shift stays in 8 bits
    assign samp_mult = 8'h01 << ((4'(pga_gain) + 4'(oversampling_rate_factor) > 4'h7) ? 3'h7
                       : 3'(pga_gain + oversampling_rate_factor));
    assign ref_enable = ctl_r[arb_pkg::CW_REFO];
    assign bias_enable = ctl_r[arb_pkg::CW_BIAS];
    assign in_convert = (seq_r == arb_pkg::SEQ_CONV);
    assign data_ready = rdy_r;

endmodule

// ==== design/arb_correct.sv ====
// offset and gain correction of one raw conversion value
// assumes raw values arrive as one-cycle strobes on the block clock
module arb_correct (
    // ************************************************************
    // clock and reset
    // ************************************************************
    input wire logic clock,
    input wire logic rstn,
    // ************************************************************
    // raw sample and trims
    // ************************************************************
    input wire logic [23:0] raw,
    input wire logic raw_valid,
    input wire logic [23:0] ofs,
    input wire logic [23:0] gain,
    // ************************************************************
    // corrected sample
    // ************************************************************
    output logic [23:0] corr,
    output logic corr_valid
);

    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [27:0] scaled;
    logic [23:0] sat;
    logic [23:0] corr_r;
    logic valid_r;

    assign diff = $signed({raw[23], raw}) - $signed({ofs[23], ofs});
    // widen both factors first, or the product is formed at 25 bits and wraps
    assign prod = 50'(diff) * 50'($signed({1'b0, gain}));
    assign scaled = prod[arb_pkg::GAN_SHIFT +: 28];
    // saturate rather than wrap, so a large trim never flips the sign
    assign sat = (scaled > 28'sh07f_ffff) ? 24'h7f_ffff :
                 (scaled < -28'sh080_0000) ? 24'h80_0000 : scaled[23:0];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            corr_r <= 24'h00_0000;
            valid_r <= 1'b0;
        end else begin
            corr_r <= raw_valid ? sat : corr_r;
            valid_r <= raw_valid;
        end
    end

    assign corr = corr_r;
    assign corr_valid = valid_r;

endmodule

// ==== design/arb_pkg.sv ====
// package of constants and carriers for the converter register bank
// assumes a single 100 MHz clock domain and a serial port sampled on it
package arb_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [3:0] A_RES_B2 = 4'h0;
    localparam logic [3:0] A_RES_B0 = 4'h2;
    localparam logic [3:0] A_CTL_B3 = 4'h4;
    localparam logic [3:0] A_CTL_B0 = 4'h7;
    localparam logic [3:0] A_OFS_B2 = 4'h8;
    localparam logic [3:0] A_OFS_B0 = 4'ha;
    localparam logic [3:0] A_GAN_B2 = 4'hc;
    localparam logic [3:0] A_GAN_B0 = 4'he;

    // ************************************************************
    // control word fields and reset values
    // ************************************************************
    localparam int CW_BIAS = 31;
    localparam int CW_REFO = 30;
    localparam int CW_DF = 29;
    localparam int CW_UB = 28;
    localparam int CW_BD = 27;
    localparam int CW_DRDY = 24;
    localparam int CW_MD_LO = 21;
    localparam int CW_G_LO = 18;
    localparam int CW_SF_LO = 13;
    localparam int CW_DR_LO = 0;
    localparam logic [31:0] CW_RESET = 32'h4000_0017;
    localparam logic [23:0] OFS_RESET = 24'h00_0000;
    // unity gain trim: 1.0 is bit 22
    localparam logic [23:0] GAN_RESET = 24'h40_0000;
    localparam int GAN_SHIFT = 22;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int CAL_RATE_HZ = 850;
    localparam int XIN_HZ = 10_000_000;
    localparam int DECIM_DIV = 512;
    // decimation value giving the calibration data rate from the master clock
    localparam logic [12:0] CAL_DECIM = 13'((XIN_HZ / (DECIM_DIV * CAL_RATE_HZ)) - 1);
    // sample index used for offset capture, after the filter has filled
    localparam logic [1:0] CAL_FILL = 2'h3;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic rd;
        logic [1:0] nbytes;
        logic zero;
        logic [3:0] addr;
    } arb_ins_s;

    typedef enum logic [1:0] {
        SEQ_RESET = 2'b00,
        SEQ_CAL = 2'b01,
        SEQ_CONV = 2'b10
    } arb_seq_e;

endpackage

// ==== sim/arb_bank_checker.sv ====
// assertions on the ports of the converter register bank
// assumes one clock domain and an active low asynchronous reset
module arb_bank_checker #(
    parameter int SETTLE_CYC = 256
) (
    // clock, reset, serial side
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sdio_oe,
    // converter side
    input wire logic raw_valid,
    input wire logic cal_short,
    input wire logic [12:0] decimation,
    input wire logic [2:0] pga_gain,
    input wire logic [2:0] oversampling_rate_factor,
    input wire logic [7:0] samp_mult,
    input wire logic ref_enable,
    input wire logic bias_enable,
    input wire logic in_convert,
    input wire logic data_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    int cnt_r;
    logic [3:0] sum_w;
    logic [7:0] mult_w;
    // cap keeps the product inside eight bits
    assign sum_w = 4'(pga_gain) + 4'(oversampling_rate_factor);
    assign mult_w = (sum_w > 4'h7) ? 8'h80 : (8'h01 << sum_w);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            cnt_r <= 0;
        else if (cnt_r < SETTLE_CYC)
            cnt_r <= cnt_r + 1;
    end
    settle_wait_a: assert property (cnt_r < SETTLE_CYC - 1 |-> !cal_short && !in_convert)
        else $error("calibration began before settling");
    cal_rate_a: assert property (!in_convert |-> decimation == arb_pkg::CAL_DECIM)
        else $error("wrong decimation before convert");
    conv_holds_a: assert property (in_convert |=> in_convert)
        else $error("convert state left");
    conv_no_cal_a: assert property (in_convert |-> !cal_short)
        else $error("input shorted in convert");
    result_ready_a: assert property (raw_valid && in_convert |-> ##[2:3] data_ready)
        else $error("result not updated");
    ref_reset_a: assert property ($rose(rstn) |-> ref_enable)
        else $error("reference off after reset");
    bias_reset_a: assert property ($rose(rstn) |-> !bias_enable)
        else $error("bias on after reset");
    samp_scale_a: assert property ($past(rstn) && $stable(pga_gain) && $stable(oversampling_rate_factor)
        |-> samp_mult == mult_w) else $error("sampling multiple wrong");
    oe_select_a: assert property (cs_n && $past(cs_n) |-> !sdio_oe)
        else $error("data line driven while deselected");
    instr_no_drive_a: assert property ($fell(cs_n) |-> !sdio_oe [*8])
        else $error("data line driven during instruction");
endmodule

bind arb_bank arb_bank_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk (
    .clock(clock), .rstn(rstn), .cs_n(cs_n), .sdio_oe(sdio_oe), .raw_valid(raw_valid),
    .cal_short(cal_short), .decimation(decimation), .pga_gain(pga_gain),
    .oversampling_rate_factor(oversampling_rate_factor), .samp_mult(samp_mult),
    .ref_enable(ref_enable), .bias_enable(bias_enable), .in_convert(in_convert), .data_ready(data_ready)
);

// ==== sim/arb_host.sv ====
// host model that drives the serial port of the register bank
// assumes pins move at the falling clock edge, sclk high three clocks and low four
module arb_host (
    // clock and returned data
    input wire logic clock,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic sdio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv;
    // the device owns the shared line only while it drives it
    assign sdio_in = sdio_oe ? sdio_out : drv;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clock);
            drv = tx[i];
            repeat (3) @(negedge clock);
            sclk = 1'b1;
            rx[i] = sdio_in;
            repeat (3) @(negedge clock);
            sclk = 1'b0;
        end
    endtask
    // every transaction opens with the instruction byte
    task automatic run(input logic [7:0] ins, input int n, input logic [31:0] wdat, output logic [31:0] rdat);
        logic [7:0] b;
        @(negedge clock);
        cs_n = 1'b0;
        xfer(ins, b);
        rdat = '0;
        for (int k = 0; k < n; k++) begin
            xfer(wdat[31 - 8 * k -: 8], b);
            rdat = {rdat[23:0], b};
        end
        repeat (3) @(negedge clock);
        cs_n = 1'b1;
        repeat (4) @(negedge clock);
    endtask
endmodule

// ==== sim/test_arb_bank.sv ====
// self-checking bench of the converter register bank
// assumes the host model owns the serial pins and the bench the filter side
module test_arb_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rstn, sclk, cs_n, sdio_in, sdio_out, sdio_oe, raw_valid;
    logic cal_short, ref_enable, bias_enable, in_convert, data_ready;
    logic [23:0] raw_data;
    logic [12:0] decimation;
    logic [2:0] pga_gain, oversampling_rate_factor, op_mode;
    logic [7:0] samp_mult;
    logic [31:0] rd;
    int num_errors = 0;
    int checks_done = 0;
    arb_bank #(.SETTLE_CYC(4)) i_dut (
        .clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .raw_data(raw_data), .raw_valid(raw_valid), .cal_short(cal_short),
        .decimation(decimation), .pga_gain(pga_gain), .oversampling_rate_factor(oversampling_rate_factor),
        .op_mode(op_mode), .samp_mult(samp_mult), .ref_enable(ref_enable), .bias_enable(bias_enable),
        .in_convert(in_convert), .data_ready(data_ready)
    );
    arb_host i_host (
        .clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in)
    );
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input int n, input logic [31:0] d);
        i_host.run({1'b0, 2'(n - 1), 1'b0, a}, n, d << (8 * (4 - n)), rd);
    endtask
    // n bytes from address a, first byte in the highest position used
    task automatic rdr(input logic [3:0] a, input int n, output logic [31:0] q);
        i_host.run({1'b1, 2'(n - 1), 1'b0, a}, n, 32'h0, q);
    endtask
    task automatic pulse(input logic [23:0] v);
        @(negedge clock);
        raw_data = v;
        raw_valid = 1'b1;
        @(negedge clock);
        raw_valid = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #500000;
        num_errors++;
        close_out;
    end
    initial begin
        rstn = 1'b0;
        raw_valid = 1'b0;
        raw_data = 24'h00_0000;
        repeat (6) @(negedge clock);
        chk(ref_enable, 32'h1);
        chk(bias_enable, 32'h0);
        rstn = 1'b1;
        repeat (6) @(negedge clock);
        chk(cal_short, 32'h1);
        chk(decimation, 32'(arb_pkg::CAL_DECIM));
        for (int i = 0; i < 4; i++)
            pulse(24'h00_0050 + 24'(i));
        chk(in_convert, 32'h1);
        chk(cal_short, 32'h0);
        rdr(4'h8, 3, rd);
        chk(rd, 32'h0000_0053);
        $display("power-on test done");
        rdr(4'h4, 4, rd);
        chk(rd, arb_pkg::CW_RESET);
        rdr(4'h3, 1, rd);
        chk(rd, 32'h0);
        // gain and factor pairs, the last one past the cap
        for (int g = 2; g < 5; g += 2) begin
            wr(4'h5, 2, {16'h0, 3'(g / 2), 3'(g), 2'h0, 3'(g + 1 + g / 4), 5'h00});
            chk(op_mode, 32'(g / 2));
            chk(pga_gain, 32'(g));
            chk(oversampling_rate_factor, 32'(g + 1 + g / 4));
            chk(samp_mult, (g == 2) ? 32'h20 : 32'h80);
        end
        wr(4'h7, 1, 32'h23);
        chk(decimation, 32'h23);
        wr(4'h4, 1, 32'h80);
        chk(bias_enable, 32'h1);
        chk(ref_enable, 32'h0);
        $display("control test done");
        wr(4'h0, 3, 32'h12_3456);
        rdr(4'h0, 3, rd);
        chk(rd, 32'h0012_3456);
        wr(4'h8, 3, 32'h00_0100);
        wr(4'hc, 3, 32'h20_0000);
        rdr(4'hc, 3, rd);
        chk(rd, 32'h0020_0000);
        pulse(24'h00_1000);
        chk(data_ready, 32'h1);
        rdr(4'h0, 3, rd);
        chk(rd, 32'h0000_0780);
        chk(data_ready, 32'h0);
        $display("conversion test done");
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
        chk(ref_enable, 32'h1);
        chk(bias_enable, 32'h0);
        chk(in_convert, 32'h0);
        $display("second reset test done");
        close_out;
    end
endmodule
